// file: src/pot_access_pkg.sv
// constants, carriers and lookups shared by the wiper and eeprom serial access logic
package pot_access_pkg;

	// slave address fields
	localparam logic [6:0] POT_DEV_ID = 7'h57;
	localparam logic [6:0] EE_DEV_ID = 7'h50;
	localparam logic [7:0] POT_WR_ADDR_BYTE = 8'hae;
	localparam int RW_BIT = 0;

	// instruction byte fields
	localparam int WRITE_TYPE_BIT = 7;
	localparam logic [1:0] SEL_64 = 2'h0;
	localparam logic [1:0] SEL_100 = 2'h1;
	localparam logic [1:0] SEL_256 = 2'h2;
	localparam logic [1:0] SEL_RSVD = 2'h3;

	// wiper limits and shipped contents
	localparam logic [7:0] MAX_64 = 8'h3f;
	localparam logic [7:0] MAX_100 = 8'h63;
	localparam logic [7:0] MAX_256 = 8'hff;
	localparam logic [7:0] NV_SHIPPED = 8'h00;

	// bit slot counts within one byte frame
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BYTE_DONE = 4'h9;

	// nonvolatile write cycle time
	localparam int WRITE_CYCLE_MS = 5;
	localparam int CLOCK_KHZ = 250000;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * CLOCK_KHZ;

	typedef struct packed {
		logic [5:0] tap0;
		logic [6:0] tap1;
		logic [7:0] tap2;
	} wiper_taps_s;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} ee_write_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_INSTR,
		ST_DDATA,
		ST_EADDR,
		ST_EDATA,
		ST_TXACK,
		ST_TX,
		ST_SKIP
	} link_state_e;

	// data-to-tap translation of the 100-tap wiper; swap this body for the real table
	function automatic logic [6:0] tap100_map(input logic [7:0] d);
		logic [7:0] t;
		t = (d > MAX_100) ? MAX_100 : d;
		return t[6:0];
	endfunction

endpackage

// file: src/link_bit_capture.sv
// samples sda on each rising scl edge and hands the bit to the system clock by toggle
module link_bit_capture (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic bit_evt_o,
	output logic bit_val_o
);

	logic bit_q;
	logic tog_q;
	logic [1:0] tog_sync_q;
	logic tog_seen_q;

	// scl stands still between frames, so this side only gets a constant at reset
	always_ff @(posedge scl_i or posedge rst_i) begin
		if (rst_i) begin
			bit_q <= 1'b1;
			tog_q <= 1'b0;
		end else begin
			bit_q <= sda_i;
			tog_q <= ~tog_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tog_sync_q <= 2'b00;
			tog_seen_q <= 1'b0;
			bit_evt_o <= 1'b0;
			bit_val_o <= 1'b1;
		end else begin
			tog_sync_q <= {tog_sync_q[0], tog_q};
			tog_seen_q <= tog_sync_q[1];
			bit_evt_o <= tog_sync_q[1] ^ tog_seen_q;
			// bit_q changes on the same scl edge as the toggle, so it has settled once the toggle is seen here
			if (tog_sync_q[1] ^ tog_seen_q) begin
				bit_val_o <= bit_q;
			end
		end
	end

endmodule

// file: src/pot_wiper_eeprom_serial_access.sv
// two-wire slave for three wiper registers, their nonvolatile stores and eeprom byte writes

// Operation
// - nonvolatile wiper write updates both wiper register and its nonvolatile store
// - volatile wiper write updates only the wiper register, store stays untouched
// - wiper write is slave address, instruction byte, then one data byte
// - instruction decoded only under address 1010111; low two bits pick the wiper
// - instruction top bit picks nonvolatile (1) or volatile (0) write; ignored on reads
// - latch clear aborts any write and withholds acknowledge after the data byte
// - slave address byte 10101110 is acknowledged
// - valid instruction byte acknowledged; it selects wiper and write type
// - data byte lands in the wiper register at the rising edge carrying data_lsb
// - select 00 is 64-tap max 3Fh, 01 100-tap, 10 256-tap max FFh
// - select 11 reserved; instruction byte carrying it gets no acknowledge
// - data above a wiper's maximum sets its top tap, never wraps
// - 64-tap and 256-tap data maps directly to tap number
// - shipped nonvolatile stores hold 00h, lowest tap
// - readback starts with dummy write of address and instruction; both acknowledged
// - repeated start, read address acknowledged, selected wiper byte returned, then stop
// - readback top bits undefined for 64-tap and 100-tap, all valid for 256-tap
// - eeprom selected by address 1010000, last bit 1 read, 0 write; only the write (0) is acknowledged here
// - eeprom address byte spans 00h to FFh
// - eeprom byte write acknowledges address and data; stop starts the write cycle
// - during the write cycle all requests are ignored and sda stays released
// - write aimed at a locked eeprom region gets no acknowledge after the address
// - write cycle lasts 5 ms; any slave address is refused until it ends
// - at power-up each wiper register loads from its nonvolatile store
// - stop inside a data byte or before its acknowledge cancels the pending write
module pot_wiper_eeprom_serial_access
	import pot_access_pkg::*;
#(
	parameter int WC_CYCLES = WRITE_CYCLE_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic write_enable_latch_i,
	input wire logic lock_en_i,
	input wire logic [7:0] lock_from_i,
	input wire logic factory_i,
	output wiper_taps_s taps_o,
	output ee_write_s ee_wr_o,
	output logic busy_o
);

	localparam int WCW = $clog2(WC_CYCLES + 1);

	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic start_evt;
	logic stop_evt;
	logic scl_fall;
	logic bit_evt;
	logic bit_val;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] rx_byte;
	logic mack_q;
	link_state_e state_q;
	link_state_e nxt_c;
	logic ack_c;
	logic sda_oe_q;
	logic [1:0] sel_q;
	logic wt_q;
	logic [7:0] tx_q;
	logic [2:0][7:0] wiper_counter_reg;
	logic [2:0][7:0] wiper_nv_store;
	wiper_taps_s taps_q;
	logic nv_pend_q;
	logic [7:0] nv_data_q;
	logic ee_pend_q;
	logic [7:0] ee_addr_q;
	logic [7:0] ee_data_q;
	ee_write_s ee_wr_q;
	logic busy_q;
	logic [WCW-1:0] wc_cnt_q;

	// tap position for a given wiper and data byte
	function automatic logic [7:0] tap_of(input logic [1:0] sel, input logic [7:0] d);
		logic [7:0] t;
		t = d;
		case (sel)
			SEL_64: t = (d > MAX_64) ? MAX_64 : d;
			SEL_100: t = {1'b0, tap100_map(d)};
			default: t = d;
		endcase
		return t;
	endfunction

	link_bit_capture u_capture (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.bit_evt_o(bit_evt),
		.bit_val_o(bit_val)
	);

	// pin levels for start/stop and scl falling-edge detection
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign start_evt = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
	assign stop_evt = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
	assign scl_fall = scl_prev_q & ~scl_sync_q[1];
	assign rx_byte = {shift_q[6:0], bit_val};

	// bit counter and receive shifter
	always_ff @(posedge clock_i) begin
		if (rst_i || start_evt || stop_evt) begin
			cnt_q <= 4'h0;
			if (rst_i) begin
				shift_q <= 8'h00;
				mack_q <= 1'b1;
			end
		end else if (bit_evt && cnt_q < BYTE_DONE) begin
			if (cnt_q < ACK_SLOT) begin
				shift_q <= rx_byte;
			end else begin
				mack_q <= bit_val;
			end
			cnt_q <= cnt_q + 4'h1;
		end else if (scl_fall && cnt_q == BYTE_DONE) begin
			cnt_q <= 4'h0;
		end
	end

	// acknowledge decision for the byte just received
	always_comb begin
		ack_c = 1'b0;
		nxt_c = ST_SKIP;
		case (state_q)
			ST_ADDR: begin
				if (!busy_q) begin
					if (shift_q[7:1] == POT_DEV_ID) begin
						ack_c = 1'b1;
						nxt_c = shift_q[RW_BIT] ? ST_TXACK : ST_INSTR;
					end else if (shift_q[7:1] == EE_DEV_ID && !shift_q[RW_BIT]) begin
						ack_c = 1'b1;
						nxt_c = ST_EADDR;
					end
				end
			end
			ST_INSTR: begin
				if (shift_q[1:0] != SEL_RSVD) begin
					ack_c = 1'b1;
					nxt_c = ST_DDATA;
				end
			end
			ST_DDATA: ack_c = write_enable_latch_i;
			ST_EADDR: begin
				if (!(lock_en_i && shift_q >= lock_from_i)) begin
					ack_c = 1'b1;
					nxt_c = ST_EDATA;
				end
			end
			ST_EDATA: ack_c = write_enable_latch_i;
			default: nxt_c = ST_SKIP;
		endcase
	end

	// frame sequencing and sda drive, changed at scl falling edges and at start or stop
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_evt) begin
			state_q <= ST_ADDR;
			sda_oe_q <= 1'b0;
		end else if (stop_evt) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (scl_fall) begin
			if (cnt_q == ACK_SLOT) begin
				if (state_q == ST_TX) begin
					sda_oe_q <= 1'b0;
				end else begin
					state_q <= nxt_c;
					sda_oe_q <= ack_c;
				end
			end else if (cnt_q == BYTE_DONE) begin
				if (state_q == ST_TXACK) begin
					state_q <= ST_TX;
					sda_oe_q <= ~tx_q[7];
				end else if (state_q == ST_TX && !mack_q) begin
					sda_oe_q <= ~tx_q[7];
				end else begin
					if (state_q == ST_TX) begin
						state_q <= ST_SKIP;
					end
					sda_oe_q <= 1'b0;
				end
			end else if (state_q == ST_TX && cnt_q != 4'h0) begin
				sda_oe_q <= ~tx_q[3'h7 - cnt_q[2:0]];
			end
		end
	end

	// instruction fields and readback byte
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sel_q <= SEL_64;
			wt_q <= 1'b0;
			tx_q <= 8'h00;
		end else if (scl_fall && cnt_q == ACK_SLOT) begin
			if (state_q == ST_INSTR && ack_c) begin
				sel_q <= shift_q[1:0];
				wt_q <= shift_q[WRITE_TYPE_BIT];
			end
			if (state_q == ST_ADDR && nxt_c == ST_TXACK) begin
				// wiper register byte, not the nonvolatile store; unused top bits of the smaller wipers carry no meaning
				tx_q <= wiper_counter_reg[sel_q];
			end
		end
	end

	// wiper registers, power-up recall and nonvolatile stores
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			// the store survives reset unless the shipped contents are requested
			for (int i = 0; i < 3; i++) begin
				if (factory_i) begin
					wiper_nv_store[i] <= NV_SHIPPED;
					wiper_counter_reg[i] <= NV_SHIPPED;
				end else begin
					wiper_counter_reg[i] <= wiper_nv_store[i];
				end
			end
		end else begin
			if (bit_evt && cnt_q == LAST_DATA_BIT && state_q == ST_DDATA && write_enable_latch_i) begin
				wiper_counter_reg[sel_q] <= rx_byte;
			end
			if (stop_evt && nv_pend_q) begin
				wiper_nv_store[sel_q] <= nv_data_q;
			end
		end
	end

	// tap outputs follow the wiper registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			if (factory_i) begin
				taps_q <= '0;
			end else begin
				taps_q.tap0 <= 6'(tap_of(SEL_64, wiper_nv_store[0]));
				taps_q.tap1 <= 7'(tap_of(SEL_100, wiper_nv_store[1]));
				taps_q.tap2 <= tap_of(SEL_256, wiper_nv_store[2]);
			end
		end else if (bit_evt && cnt_q == LAST_DATA_BIT && state_q == ST_DDATA && write_enable_latch_i) begin
			case (sel_q)
				SEL_64: taps_q.tap0 <= 6'(tap_of(SEL_64, rx_byte));
				SEL_100: taps_q.tap1 <= 7'(tap_of(SEL_100, rx_byte));
				default: taps_q.tap2 <= tap_of(SEL_256, rx_byte);
			endcase
		end
	end

	// writes armed only once acknowledged, so an earlier stop cancels them
	always_ff @(posedge clock_i) begin
		if (rst_i || stop_evt) begin
			nv_pend_q <= 1'b0;
			ee_pend_q <= 1'b0;
			if (rst_i) begin
				nv_data_q <= 8'h00;
				ee_addr_q <= 8'h00;
				ee_data_q <= 8'h00;
			end
		end else if (scl_fall && cnt_q == ACK_SLOT && ack_c) begin
			if (state_q == ST_DDATA && wt_q) begin
				nv_pend_q <= 1'b1;
				nv_data_q <= shift_q;
			end
			if (state_q == ST_EADDR) begin
				ee_addr_q <= shift_q;
			end
			if (state_q == ST_EDATA) begin
				ee_pend_q <= 1'b1;
				ee_data_q <= shift_q;
			end
		end
	end

	// eeprom write strobe and the write cycle timer
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ee_wr_q <= '0;
			busy_q <= 1'b0;
			wc_cnt_q <= '0;
		end else begin
			ee_wr_q.valid <= stop_evt && ee_pend_q;
			if (stop_evt && ee_pend_q) begin
				ee_wr_q.addr <= ee_addr_q;
				ee_wr_q.data <= ee_data_q;
			end
			if (stop_evt && (ee_pend_q || nv_pend_q)) begin
				busy_q <= 1'b1;
				wc_cnt_q <= WCW'(WC_CYCLES - 1);
			end else if (busy_q) begin
				if (wc_cnt_q == '0) begin
					busy_q <= 1'b0;
				end else begin
					wc_cnt_q <= wc_cnt_q - 1'b1;
				end
			end
		end
	end

	// open-drain: the pin only ever pulls low
	always_ff @(posedge clock_i) begin
		sda_o <= 1'b0;
	end

	assign sda_oe_o = sda_oe_q;
	assign taps_o = taps_q;
	assign ee_wr_o = ee_wr_q;
	assign busy_o = busy_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_addr_ack_pot: assert property (
		(scl_fall && cnt_q == ACK_SLOT && state_q == ST_ADDR && !busy_q && shift_q == POT_WR_ADDR_BYTE)
		|=> sda_oe_q && state_q == ST_INSTR)
		else $error("wiper write address not acknowledged");

	a_busy_addr_nack: assert property (
		(scl_fall && cnt_q == ACK_SLOT && state_q == ST_ADDR && busy_q) |=> !sda_oe_q && state_q == ST_SKIP)
		else $error("address acknowledged during write cycle");

	a_busy_sda_released: assert property (
		busy_q |-> !sda_oe_q)
		else $error("sda driven during write cycle");

	a_rsvd_select_nack: assert property (
		(scl_fall && cnt_q == ACK_SLOT && state_q == ST_INSTR && shift_q[1:0] == SEL_RSVD)
		|=> !sda_oe_q && state_q == ST_SKIP)
		else $error("reserved select acknowledged");

	a_latch_data_nack: assert property (
		(scl_fall && cnt_q == ACK_SLOT && (state_q == ST_DDATA || state_q == ST_EDATA) && !write_enable_latch_i)
		|=> !sda_oe_q && !nv_pend_q && !ee_pend_q)
		else $error("data acknowledged with write enable latch clear");

	a_wiper_latch: assert property (
		(bit_evt && cnt_q == LAST_DATA_BIT && state_q == ST_DDATA && write_enable_latch_i)
		|=> wiper_counter_reg[$past(sel_q)] == $past(rx_byte))
		else $error("wiper register missed the data byte");

	a_top_tap_clamp: assert property (
		(bit_evt && cnt_q == LAST_DATA_BIT && state_q == ST_DDATA && write_enable_latch_i
		&& sel_q == SEL_64 && rx_byte > MAX_64) |=> taps_q.tap0 == 6'h3f)
		else $error("64-tap wiper wrapped instead of clamping");

	a_nv_commit: assert property (
		(stop_evt && nv_pend_q) |=> wiper_nv_store[$past(sel_q)] == $past(nv_data_q) && busy_q)
		else $error("nonvolatile store not written at stop");

	a_volatile_keeps_nv: assert property (
		!nv_pend_q |=> $stable(wiper_nv_store))
		else $error("nonvolatile store changed without a nonvolatile write");

	a_locked_addr_nack: assert property (
		(scl_fall && cnt_q == ACK_SLOT && state_q == ST_EADDR && lock_en_i && shift_q >= lock_from_i)
		|=> !sda_oe_q ##1 !ee_pend_q)
		else $error("locked eeprom address acknowledged");

	a_ee_commit: assert property (
		(stop_evt && ee_pend_q) |=> ee_wr_q.valid && ee_wr_q.data == $past(ee_data_q) ##1 !ee_wr_q.valid)
		else $error("eeprom write strobe wrong at stop");

	c_nv_write: cover property (stop_evt && nv_pend_q);
	c_ee_write: cover property (stop_evt && ee_pend_q);
	c_readback: cover property (state_q == ST_TXACK ##[1:300] state_q == ST_TX);
	c_rsvd_nack: cover property (scl_fall && cnt_q == ACK_SLOT && state_q == ST_INSTR && shift_q[1:0] == SEL_RSVD);

endmodule

// file: testbench/link_master_model.sv
// two-wire bus master model: drives scl and pulls sda low, the wire has a pull-up
module link_master_model (
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// scl period is four quarter phases, 48 ns in all
	localparam time PH = 12ns;
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// scl stands high outside frames; also serves as repeated start
	task automatic start();
		pull_o = 1'b0;
		// a slave releasing its acknowledge late must not look like a stop
		#(2 * PH);
		scl_o = 1'b1;
		#(2 * PH);
		pull_o = 1'b1;
		#(2 * PH);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		#(PH);
		pull_o = 1'b1;
		#(PH);
		scl_o = 1'b1;
		#(2 * PH);
		pull_o = 1'b0;
		#(2 * PH);
	endtask
	task automatic clk_bit(input logic b, output logic s);
		#(PH);
		pull_o = ~b;
		#(PH);
		scl_o = 1'b1;
		#(PH);
		s = sda_i;
		#(PH);
		scl_o = 1'b0;
	endtask
	task automatic send8(input logic [7:0] d);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			clk_bit(d[k], s);
		end
	endtask
	// bytes go msb first, the ninth clock carries the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		send8(d);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic s;
		for (int k = 7; k >= 0; k--) begin
			clk_bit(1'b1, d[k]);
		end
		clk_bit(~mack, s);
	endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the wiper and eeprom serial access block
module testbench
	import pot_access_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WC = 600;
	logic clock_i, rst_i, wr_en, lock_en, factory, scl, pull, sda_o, sda_oe, busy;
	logic [7:0] lock_from, d, r;
	logic [2:0] a;
	logic [1:0] sel;
	wire logic sda_w;
	wiper_taps_s taps;
	ee_write_s ee_wr, ee_last;
	int error_cnt = 0, checked = 0, ee_cnt = 0, oe_busy = 0, n0 = 0, seed = 32'hf620;
	assign sda_w = !((sda_oe && !sda_o) || pull);
	link_master_model mst_u (.sda_i(sda_w), .scl_o(scl), .pull_o(pull));
	pot_wiper_eeprom_serial_access #(.WC_CYCLES(WC)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .write_enable_latch_i(wr_en), .lock_en_i(lock_en),
		.lock_from_i(lock_from), .factory_i(factory), .taps_o(taps), .ee_wr_o(ee_wr), .busy_o(busy));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (ee_wr.valid === 1'b1) begin
			ee_cnt++;
			ee_last = ee_wr;
		end
		if (busy === 1'b1 && sda_oe !== 1'b0) begin
			oe_busy++;
		end
	end
	task automatic fail(input string msg);
		error_cnt++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			fail($sformatf("%s got %h exp %h", msg, got, exp));
		end
	endtask
	task automatic chk_ack(input logic got, input logic exp, input string msg);
		checked++;
		if (got !== exp) begin
			fail($sformatf("%s got %b exp %b", msg, got, exp));
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge clock_i);
			n++;
		end
		#1;
		chk_ack(busy, 1'b0, "write cycle end");
	endtask
	function automatic logic [7:0] exp_tap(input logic [1:0] s, input logic [7:0] v);
		logic [7:0] m;
		m = (s == SEL_64) ? MAX_64 : (s == SEL_100) ? MAX_100 : MAX_256;
		return (v > m) ? m : v;
	endfunction
	function automatic logic [7:0] get_tap(input logic [1:0] s);
		return (s == SEL_64) ? {2'h0, taps.tap0} : (s == SEL_100) ? {1'h0, taps.tap1} : taps.tap2;
	endfunction
	function automatic logic [7:0] rd_mask(input logic [1:0] s);
		return (s == SEL_64) ? 8'h3f : (s == SEL_100) ? 8'h7f : 8'hff;
	endfunction
	task automatic pot_wr(input logic [1:0] s, input logic nv, input logic [7:0] v, input logic [2:0] exp);
		mst_u.start();
		mst_u.wbyte(POT_WR_ADDR_BYTE, a[2]);
		mst_u.wbyte({nv, 5'h00, s}, a[1]);
		mst_u.wbyte(v, a[0]);
		mst_u.stop();
		chk_val({5'h00, a}, {5'h00, exp}, "wiper write acks");
	endtask
	// the write type bit is random here because reads must ignore it
	task automatic pot_rd(input logic [1:0] s, output logic [7:0] v);
		mst_u.start();
		mst_u.wbyte(POT_WR_ADDR_BYTE, a[2]);
		mst_u.wbyte({1'($random(seed)), 5'h00, s}, a[1]);
		mst_u.start();
		mst_u.wbyte({POT_DEV_ID, 1'b1}, a[0]);
		mst_u.rbyte(1'b0, v);
		mst_u.stop();
		chk_val({5'h00, a}, 8'h07, "readback acks");
	endtask
	task automatic ee_write(input logic [7:0] ad, input logic [7:0] v, input logic [2:0] exp);
		mst_u.start();
		mst_u.wbyte({EE_DEV_ID, 1'b0}, a[2]);
		mst_u.wbyte(ad, a[1]);
		mst_u.wbyte(v, a[0]);
		mst_u.stop();
		chk_val({5'h00, a}, {5'h00, exp}, "eeprom acks");
	endtask
	initial begin
		#300us;
		fail("watchdog expired");
		end_sim();
	end
	initial begin
		rst_i = 1'b1;
		factory = 1'b1;
		wr_en = 1'b0;
		lock_en = 1'b0;
		lock_from = 8'hff;
		repeat (16) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		factory = 1'b0;
		wait_clk(4);
		for (int k = 0; k < 3; k++) begin
			chk_val(get_tap(2'(k)), 8'h00, "shipped tap");
		end
		$display("test shipped done");
		wr_en = 1'b1;
		for (int k = 0; k < 12; k++) begin
			sel = 2'(k % 3);
			d = (k < 3) ? 8'hff : 8'($random(seed));
			pot_wr(sel, 1'b0, d, 3'h7);
			chk_val(get_tap(sel), exp_tap(sel, d), "tap after write");
			pot_rd(sel, r);
			chk_val(r & rd_mask(sel), d & rd_mask(sel), "readback");
		end
		$display("test volatile write and readback done");
		pot_wr(SEL_64, 1'b1, 8'h25, 3'h7);
		wait_clk(2);
		chk_ack(busy, 1'b1, "busy after store");
		// acknowledge polling while the store is written
		mst_u.start();
		mst_u.wbyte(POT_WR_ADDR_BYTE, a[0]);
		mst_u.stop();
		chk_ack(a[0], 1'b0, "poll while busy");
		wait_idle();
		pot_wr(SEL_256, 1'b1, 8'h5a, 3'h7);
		wait_idle();
		pot_wr(SEL_256, 1'b0, 8'h11, 3'h7);
		chk_val(get_tap(SEL_256), 8'h11, "volatile over stored");
		// stop in the middle of the data byte must drop the store write
		mst_u.start();
		mst_u.wbyte(POT_WR_ADDR_BYTE, a[2]);
		mst_u.wbyte({1'b1, 5'h00, SEL_100}, a[1]);
		d = 8'h30;
		for (int k = 7; k > 3; k--) begin
			mst_u.clk_bit(d[k], r[0]);
		end
		mst_u.stop();
		wait_clk(8);
		chk_ack(busy, 1'b0, "cancelled store");
		$display("test nonvolatile write done");
		wait_clk(1);
		wr_en = 1'b0;
		pot_wr(SEL_64, 1'b0, 8'h3f, 3'h6);
		chk_val(get_tap(SEL_64), 8'h25, "latch clear write");
		wait_clk(1);
		wr_en = 1'b1;
		pot_wr(SEL_RSVD, 1'b0, 8'h01, 3'h4);
		$display("test refused writes done");
		wait_clk(1);
		lock_en = 1'b1;
		lock_from = 8'h80;
		n0 = ee_cnt;
		ee_write(8'h80, 8'h66, 3'h4);
		ee_write(8'h7f, 8'h3c, 3'h7);
		wait_idle();
		chk_val(8'(ee_cnt - n0), 8'h01, "eeprom commits");
		chk_val(ee_last.addr, 8'h7f, "eeprom addr");
		chk_val(ee_last.data, 8'h3c, "eeprom data");
		wait_clk(1);
		lock_en = 1'b0;
		for (int k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			ee_write(k == 0 ? 8'hff : 8'h00, d, 3'h7);
			wait_idle();
			chk_val(ee_last.addr, k == 0 ? 8'hff : 8'h00, "eeprom addr bound");
			chk_val(ee_last.data, d, "eeprom data bound");
		end
		wait_clk(1);
		wr_en = 1'b0;
		n0 = ee_cnt;
		ee_write(8'h10, 8'h99, 3'h6);
		wait_clk(20);
		chk_val(8'(ee_cnt - n0), 8'h00, "eeprom without latch");
		$display("test eeprom write done");
		rst_i = 1'b1;
		wait_clk(4);
		rst_i = 1'b0;
		wait_clk(4);
		chk_val(get_tap(SEL_64), 8'h25, "recall wiper0");
		chk_val(get_tap(SEL_100), 8'h00, "recall wiper1");
		chk_val(get_tap(SEL_256), 8'h5a, "recall wiper2");
		chk_val(8'(oe_busy), 8'h00, "sda driven while busy");
		$display("test power cycle done");
		end_sim();
	end
endmodule
